// [logic/mgmt_csr_port.sv]
// What this block does
// - Management bus and reconfiguration logic run on the management clock.
// - Clock-generation reset sequencer advances on the management clock only.
// - Global reset is active high, level sensitive, held while input high.
// - Global reset clears MAC, clock PLL and PHY logic together.
// - Address width is base width plus log2 of the lane count.
// - Address top bit one selects reconfiguration space, zero soft CSRs.
// - Wait-request asserted while a pending access cannot yet complete.
// - One serial transmit and receive bit per lane.
// - Error interrupt high while any enabled error status bit is set.
`timescale 1ns/1ps
module mgmt_csr_port #(
    parameter bit extended_variant = 1'b0,
    localparam int addr_width = (extended_variant ? mgmt_port_pkg::base_width_extended
        : mgmt_port_pkg::base_width_standard) + mgmt_port_pkg::lane_bits
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Management bus
    input wire logic [addr_width-1:0] management_address,
    input wire logic [mgmt_port_pkg::data_width-1:0] management_write_bus,
    output logic [mgmt_port_pkg::data_width-1:0] management_read_bus,
    input wire logic management_write,
    input wire logic management_read,
    output logic management_wait,
    // Error events and interrupt
    input wire logic [mgmt_port_pkg::err_bits-1:0] error_events,
    output logic error_interrupt,
    // Clock generation, reset and loopback
    input wire logic pll_locked,
    output logic pll_reset,
    output logic mac_reset,
    output logic phy_reset,
    output logic [mgmt_port_pkg::lane_count-1:0] loopback_enable,
    // Reconfiguration space
    output logic reconfig_write,
    output logic reconfig_read,
    output logic [addr_width-2:0] reconfig_address,
    output logic [mgmt_port_pkg::data_width-1:0] reconfig_write_bus,
    input wire logic [mgmt_port_pkg::data_width-1:0] reconfig_read_bus,
    // Serial lanes
    input wire logic [mgmt_port_pkg::lane_count-1:0] rx_serial,
    output logic [mgmt_port_pkg::lane_count-1:0] tx_serial
);
    localparam int ew = mgmt_port_pkg::err_bits;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] lock_sync_q, lock_sync_d;
    logic lock_stable_q, lock_stable_d;

    // Lock pin through three flops, change on agreement
    always_comb begin
        lock_sync_d = {lock_sync_q[1:0], pll_locked};
        lock_stable_d = lock_stable_q;
        if (lock_sync_q[1] == lock_sync_q[2]) begin
            lock_stable_d = lock_sync_q[2];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_sync_q <= 3'h0;
            lock_stable_q <= 1'b0;
        end else begin
            lock_sync_q <= lock_sync_d;
            lock_stable_q <= lock_stable_d;
        end
    end

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    mgmt_port_pkg::reset_state_type state_q, state_d;
    logic [7:0] hold_cnt_q, hold_cnt_d;
    logic soft_reset_q, soft_reset_d;

    // Sequence PLL then MAC and PHY out of reset
    always_comb begin
        state_d = state_q;
        hold_cnt_d = hold_cnt_q;
        unique case (state_q)
            mgmt_port_pkg::st_idle: begin
                hold_cnt_d = 8'h00;
                state_d = mgmt_port_pkg::st_hold;
            end
            mgmt_port_pkg::st_hold: begin
                hold_cnt_d = hold_cnt_q + 8'h01;
                if (hold_cnt_q == mgmt_port_pkg::reset_hold_cycles - 8'h01) begin
                    state_d = mgmt_port_pkg::st_wait_lock;
                end
            end
            mgmt_port_pkg::st_wait_lock: begin
                if (lock_stable_q) begin
                    state_d = mgmt_port_pkg::st_ready;
                end
            end
            mgmt_port_pkg::st_ready: begin
                if (!lock_stable_q) begin
                    state_d = mgmt_port_pkg::st_wait_lock;
                end
            end
        endcase
        if (soft_reset_q) begin
            state_d = mgmt_port_pkg::st_idle;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= mgmt_port_pkg::st_idle;
            hold_cnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            hold_cnt_q <= hold_cnt_d;
        end
    end

    // Whole core in reset while global reset high
    assign pll_reset = rst || state_q == mgmt_port_pkg::st_idle
        || state_q == mgmt_port_pkg::st_hold;
    assign mac_reset = rst || state_q != mgmt_port_pkg::st_ready;
    assign phy_reset = mac_reset;

    // ------------------------------------------------------------
    // Bus decode and soft CSRs
    // ------------------------------------------------------------
    logic [ew-1:0] err_status_q, err_status_d;
    logic [ew-1:0] err_enable_q, err_enable_d;
    logic [mgmt_port_pkg::lane_count-1:0] loop_q, loop_d;
    logic [mgmt_port_pkg::data_width-1:0] rdata_q, rdata_d;
    logic [1:0] busy_cnt_q, busy_cnt_d;
    logic pending_q, pending_d;
    logic irq_q, irq_d;
    logic sel_reconfig, req, soft_wr, soft_rd, reconf_done;
    logic [3:0] csr_index;

    assign sel_reconfig = management_address[addr_width-1];
    assign req = management_read || management_write;
    assign csr_index = management_address[3:0];
    assign soft_wr = management_write && !sel_reconfig;
    assign soft_rd = management_read && !sel_reconfig;
    assign reconf_done = pending_q && busy_cnt_q == mgmt_port_pkg::reconfig_latency;

    // Reconfiguration access passes straight through, held by host
    assign reconfig_write = management_write && sel_reconfig;
    assign reconfig_read = management_read && sel_reconfig;
    assign reconfig_address = management_address[addr_width-2:0];
    assign reconfig_write_bus = management_write_bus;

    // Soft accesses finish after one wait cycle, reconfig after fixed latency
    assign management_wait = req && (sel_reconfig ? !reconf_done : !pending_q);

    // Register update and read mux
    always_comb begin
        err_enable_d = err_enable_q;
        loop_d = loop_q;
        soft_reset_d = 1'b0;
        rdata_d = rdata_q;
        pending_d = req && management_wait;
        busy_cnt_d = (req && sel_reconfig && !reconf_done) ? busy_cnt_q + 2'h1 : 2'h0;
        err_status_d = err_status_q;
        if (soft_wr && pending_q) begin
            unique case (csr_index)
                mgmt_port_pkg::csr_reset_ctrl: soft_reset_d = management_write_bus[0];
                mgmt_port_pkg::csr_loopback:
                    loop_d = management_write_bus[mgmt_port_pkg::lane_count-1:0];
                mgmt_port_pkg::csr_err_status:
                    err_status_d = err_status_q & ~management_write_bus[ew-1:0];
                mgmt_port_pkg::csr_err_enable: err_enable_d = management_write_bus[ew-1:0];
                default: begin
                end
            endcase
        end
        // New events win over a write-one clear
        err_status_d = err_status_d | error_events;
        if (soft_rd && pending_q) begin
            rdata_d = '0;
            unique case (csr_index)
                mgmt_port_pkg::csr_loopback: rdata_d[mgmt_port_pkg::lane_count-1:0] = loop_q;
                mgmt_port_pkg::csr_err_status: rdata_d[ew-1:0] = err_status_q;
                mgmt_port_pkg::csr_err_enable: rdata_d[ew-1:0] = err_enable_q;
                mgmt_port_pkg::csr_reset_state: rdata_d[3:0] = state_q;
                default: rdata_d = '0;
            endcase
        end else if (management_read && reconf_done) begin
            rdata_d = reconfig_read_bus;
        end
        irq_d = |(err_status_d & err_enable_d);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_status_q <= '0;
            err_enable_q <= '0;
            loop_q <= '0;
            soft_reset_q <= 1'b0;
            rdata_q <= '0;
            busy_cnt_q <= 2'h0;
            pending_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            err_status_q <= err_status_d;
            err_enable_q <= err_enable_d;
            loop_q <= loop_d;
            soft_reset_q <= soft_reset_d;
            rdata_q <= rdata_d;
            busy_cnt_q <= busy_cnt_d;
            pending_q <= pending_d;
            irq_q <= irq_d;
        end
    end

    assign management_read_bus = rdata_q;
    assign error_interrupt = irq_q;
    assign loopback_enable = loop_q;

    // ------------------------------------------------------------
    // Serial lanes
    // ------------------------------------------------------------
    logic [mgmt_port_pkg::lane_count-1:0] rx_s0_q, rx_s1_q, rx_s2_q, rx_stable_q;
    logic [mgmt_port_pkg::lane_count-1:0] rx_s0_d, rx_s1_d, rx_s2_d, rx_stable_d;
    logic [mgmt_port_pkg::lane_count-1:0] tx_q, tx_d;

    // Receive pins through three flops, a bit moves once the last two agree
    // Loopback lanes return the settled bit, other lanes and all lanes in reset idle low
    always_comb begin
        rx_s0_d = rx_serial;
        rx_s1_d = rx_s0_q;
        rx_s2_d = rx_s1_q;
        rx_stable_d = (rx_s1_q & rx_s2_q) | (rx_stable_q & (rx_s1_q | rx_s2_q));
        tx_d = mac_reset ? '0 : (rx_stable_q & loop_q);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_s0_q <= '0;
            rx_s1_q <= '0;
            rx_s2_q <= '0;
            rx_stable_q <= '0;
            tx_q <= '0;
        end else begin
            rx_s0_q <= rx_s0_d;
            rx_s1_q <= rx_s1_d;
            rx_s2_q <= rx_s2_d;
            rx_stable_q <= rx_stable_d;
            tx_q <= tx_d;
        end
    end

    assign tx_serial = tx_q;
endmodule

// [logic/mgmt_port_pkg.sv]
package mgmt_port_pkg;
    // --------------------------------------------------------------
    // Geometry
    // --------------------------------------------------------------
    localparam int lane_count = 4;
    localparam int lane_bits = $clog2(lane_count);
    localparam int base_width_standard = 12;
    localparam int base_width_extended = 20;
    localparam int data_width = 32;

    // --------------------------------------------------------------
    // Soft CSR map (word index within soft space)
    // --------------------------------------------------------------
    localparam logic [3:0] csr_reset_ctrl = 4'h0;
    localparam logic [3:0] csr_loopback = 4'h1;
    localparam logic [3:0] csr_err_status = 4'h2;
    localparam logic [3:0] csr_err_enable = 4'h3;
    localparam logic [3:0] csr_reset_state = 4'h4;
    localparam int err_bits = lane_count + 5;

    // --------------------------------------------------------------
    // Reset sequencing and reconfiguration latency
    // --------------------------------------------------------------
    localparam logic [7:0] reset_hold_cycles = 8'h10;
    localparam logic [1:0] reconfig_latency = 2'h2;

    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_hold = 4'b0010,
        st_wait_lock = 4'b0100,
        st_ready = 4'b1000
    } reset_state_type;
endpackage

// [testbench/mgmt_csr_port_assertions.sv]
`timescale 1ns/1ps
module mgmt_csr_port_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire logic [13:0] management_address,
    input wire logic management_write,
    input wire logic management_read,
    input wire logic management_wait,
    input wire logic mac_reset,
    input wire logic phy_reset,
    input wire logic pll_reset,
    input wire logic error_interrupt,
    input wire logic reconfig_write,
    input wire logic reconfig_read,
    input wire logic [12:0] reconfig_address,
    input wire logic [3:0] loopback_enable,
    input wire logic [3:0] tx_serial
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // -----------------------------------------
    // Properties
    // -----------------------------------------
    a_reset_all: assert property (disable iff (1'b0) rst |-> mac_reset && phy_reset && pll_reset
        && !error_interrupt && tx_serial == 4'h0) else $error("reset outputs wrong");
    a_seq_hold: assert property ($past(rst) |-> (mac_reset && phy_reset) [*8])
        else $error("core left reset too early");
    a_wait_first: assert property ((management_write || management_read)
        && !$past(management_write || management_read) |-> management_wait)
        else $error("no wait on new request");
    a_wait_bound: assert property ($rose(management_write || management_read)
        |-> ##[0:8] !management_wait) else $error("wait never dropped");
    a_route_reconfig: assert property (management_write && management_address[13]
        |-> reconfig_write) else $error("reconfig write not routed");
    a_route_soft: assert property (!management_address[13]
        |-> !reconfig_write && !reconfig_read) else $error("soft access leaked");
    a_reconfig_addr: assert property (reconfig_write || reconfig_read
        |-> reconfig_address == management_address[12:0]) else $error("reconfig address");
    a_tx_masked: assert property ((tx_serial & ~$past(loopback_enable)) == 4'h0)
        else $error("tx outside loopback lanes");
endmodule
bind mgmt_csr_port mgmt_csr_port_checker u_chk (.clk(clk), .rst(rst),
    .management_address(management_address), .management_write(management_write),
    .management_read(management_read), .management_wait(management_wait),
    .mac_reset(mac_reset), .phy_reset(phy_reset), .pll_reset(pll_reset),
    .error_interrupt(error_interrupt), .reconfig_write(reconfig_write),
    .reconfig_read(reconfig_read), .reconfig_address(reconfig_address),
    .loopback_enable(loopback_enable), .tx_serial(tx_serial));

// [testbench/mgmt_csr_port_tb_top.sv]
`timescale 1ns/1ps
module mgmt_csr_port_tb_top;
    logic clk, rst, wr, rd, wt, irq, locked, pll_r, mac_r, phy_r, rc_wr, rc_rd;
    logic [13:0] addr;
    logic [31:0] wdata, rdata, rc_wdata, rc_rdata, q;
    logic [8:0] err_ev;
    logic [12:0] rc_addr;
    logic [3:0] lb, rx, tx;
    logic [12:0] rc_addr_seen;
    logic [31:0] rc_data_seen;
    int rc_writes = 0;
    int rc_reads = 0;
    int n_errors = 0;
    int n_checks = 0;
    mgmt_csr_port dut (.clk(clk), .rst(rst), .management_address(addr),
        .management_write_bus(wdata), .management_read_bus(rdata), .management_write(wr),
        .management_read(rd), .management_wait(wt), .error_events(err_ev),
        .error_interrupt(irq), .pll_locked(locked), .pll_reset(pll_r), .mac_reset(mac_r),
        .phy_reset(phy_r), .loopback_enable(lb), .reconfig_write(rc_wr),
        .reconfig_read(rc_rd), .reconfig_address(rc_addr), .reconfig_write_bus(rc_wdata),
        .reconfig_read_bus(rc_rdata), .rx_serial(rx), .tx_serial(tx));
    mgmt_host_model host (.clk(clk), .address(addr), .wdata(wdata), .write(wr), .read(rd),
        .wait_req(wt), .rdata(rdata));
    // Clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Far-side record of completed reconfiguration accesses
    always @(posedge clk) begin
        if (rc_wr === 1'b1 && wt === 1'b0) begin
            rc_addr_seen <= rc_addr;
            rc_data_seen <= rc_wdata;
            rc_writes <= rc_writes + 1;
        end
        if (rc_rd === 1'b1 && wt === 1'b0) begin
            rc_reads <= rc_reads + 1;
        end
    end
    // -----------------------------------------
    // Shared tasks
    // -----------------------------------------
    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic bus(input bit w, input logic [13:0] a, input logic [31:0] d);
        bit ok;
        host.access(w, a, d, q, ok);
        if (!ok) begin
            n_errors++;
            print_verdict();
        end
    endtask
    // -----------------------------------------
    // Scenarios
    // -----------------------------------------
    task automatic wait_ready();
        int n;
        for (n = 0; n < 60 && mac_r !== 1'b0; n++) @(negedge clk);
        if (mac_r !== 1'b0) begin
            n_errors++;
            print_verdict();
        end
    endtask
    task automatic t_sequencer();
        wait_ready();
        check(32'(mac_r | phy_r), 32'h0, "core still in reset");
        bus(1'b0, 14'h0004, 32'h0);
        check(q, 32'h0000_0008, "sequencer not ready");
        bus(1'b1, 14'h0000, 32'h0000_0001);
        bus(1'b0, 14'h0004, 32'h0);
        check(q, 32'h0000_0002, "soft restart not seen");
        check(32'(mac_r), 32'h1, "core not back in reset");
        wait_ready();
        check(32'(mac_r | phy_r | pll_r), 32'h0, "core stuck after restart");
    endtask
    task automatic t_loopback();
        bus(1'b1, 14'h0001, 32'h0000_000a);
        bus(1'b0, 14'h0001, 32'h0);
        check(q, 32'h0000_000a, "loopback readback");
        check(32'(lb), 32'h0000_000a, "loopback lanes");
        rx = 4'hf;
        repeat (6) @(negedge clk);
        check(32'(tx), 32'h0000_000a, "tx lanes");
        bus(1'b0, 14'h000f, 32'h0);
        check(q, 32'h0, "unmapped read");
    endtask
    task automatic t_irq();
        err_ev = 9'h004;
        @(negedge clk);
        err_ev = 9'h000;
        repeat (3) @(negedge clk);
        check(32'(irq), 32'h0, "irq while masked");
        bus(1'b1, 14'h0003, 32'h0000_0004);
        repeat (2) @(negedge clk);
        check(32'(irq), 32'h1, "irq not raised");
        bus(1'b1, 14'h0002, 32'h0000_0004);
        repeat (2) @(negedge clk);
        check(32'(irq), 32'h0, "irq not cleared");
    endtask
    task automatic t_reconfig();
        bus(1'b1, 14'h2005, 32'h1234_5678);
        bus(1'b0, 14'h3fff, 32'h0);
        check(q, 32'h5a5a_c3c3, "reconfig read data");
        check(32'(rc_writes), 32'h1, "reconfig write count");
        check(32'(rc_reads), 32'h1, "reconfig read count");
        check(32'(rc_addr_seen), 32'h0000_0005, "reconfig address");
        check(rc_data_seen, 32'h1234_5678, "reconfig write data");
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        err_ev = 9'h000;
        locked = 1'b1;
        rx = 4'h0;
        rc_rdata = 32'h5a5a_c3c3;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check(32'({mac_r, phy_r, pll_r, irq}), 32'he, "reset outputs");
        rst = 1'b0;
        t_sequencer();
        t_loopback();
        t_irq();
        t_reconfig();
        print_verdict();
    end
endmodule

// [testbench/mgmt_host_model.sv]
`timescale 1ns/1ps
module mgmt_host_model (
    // Clock
    input wire logic clk,
    // Management bus
    output logic [13:0] address,
    output logic [31:0] wdata,
    output logic write,
    output logic read,
    input wire logic wait_req,
    input wire logic [31:0] rdata
);
    // Idle bus at time zero
    initial begin
        address = 14'h0000;
        wdata = 32'h0000_0000;
        write = 1'b0;
        read = 1'b0;
    end
    // One access, held until wait is sampled low
    task automatic access(input bit wr, input logic [13:0] a, input logic [31:0] d,
            output logic [31:0] q, output bit ok);
        int n;
        n = 0;
        @(negedge clk);
        address = a;
        wdata = d;
        write = wr;
        read = !wr;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 40);
        ok = (wait_req === 1'b0);
        @(negedge clk);
        q = rdata;
        write = 1'b0;
        read = 1'b0;
        address = ~a; // Released lines show no stale value
        wdata = ~d;
    endtask
endmodule
